// [design/pin_reset_state_and_straps.sv]
`timescale 1ns/10ps
// Operation
// RL1: During main reset every transmit data pair shows differential high.
// RL2: During main reset every transmit control pair shows differential low.
// RL3: High means positive leg high, negative low; low is the reverse.
// RL4: Normal mode: slot signals reset on secondary reset, others on main reset.
// RL5: Single-slot mode: reset pin states follow only the main reset.
// RL6: Normal: data and byte enables low in reset, parked after; single-slot low.
// RL7: Normal: wide ack, frame, initiator ready float; single-slot drives them low.
// RL8: Target select floats or follows init pattern in reset; single-slot low.
// RL9: Strap grants are inputs while power not good; grants 4,3 pick frequency.
// RL10: Bridge B grant two strap sets default of its single-slot select bit.
// RL11: Select low with hot plug gives single-slot pin states without switches.
// RL12: Hot plug enable turns grant four into the output reset latch clock.
// RL13: Normal: grants high; single-slot: grant zero low, grants four..one high.
// RL14: A strap tells if bridge A is default bus; shown as a status bit.
// RL15: Secondary reset follows main reset or software bit; resets nothing inside.
// RL16: Input-load and output-data pins strap hot plug enables, then drive.
// RL17: Straps latch at power good rise and hold until it falls.
module pin_reset_state_and_straps #(
   parameter logic SSS_N_A_DFLT = 1'b1
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic POWER_GOOD,
   // Register port
   input wire logic [pin_state_pkg::ADDR_W-1:0] ADDR,
   input wire logic [pin_state_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [pin_state_pkg::DATA_W-1:0] RDATA,
   // Link transmit values from the link core
   input wire logic [pin_state_pkg::CAD_A_W-1:0] TX_CAD_A_IN,
   input wire logic [pin_state_pkg::CAD_B_W-1:0] TX_CAD_B_IN,
   input wire logic [1:0] TX_CTL_IN,
   // Link transmit pairs
   output logic [pin_state_pkg::CAD_A_W-1:0] SIDE_A_TX_CAD_PAIR_P,
   output logic [pin_state_pkg::CAD_A_W-1:0] SIDE_A_TX_CAD_PAIR_N,
   output logic [pin_state_pkg::CAD_B_W-1:0] SIDE_B_TX_CAD_PAIR_P,
   output logic [pin_state_pkg::CAD_B_W-1:0] SIDE_B_TX_CAD_PAIR_N,
   output logic [1:0] TX_CONTROL_PAIR_P,
   output logic [1:0] TX_CONTROL_PAIR_N,
   // Strap pins
   input wire logic DEFAULT_BUS_STRAP,
   input wire logic HP_SERIAL_IN_LOAD_N_I,
   output logic HP_SERIAL_IN_LOAD_N_O,
   output logic HP_SERIAL_IN_LOAD_N_OE,
   input wire logic HP_SERIAL_OUT_DATA_I,
   output logic HP_SERIAL_OUT_DATA_O,
   output logic HP_SERIAL_OUT_DATA_OE,
   // Hot plug serial values from the hot plug logic
   input wire logic HP_LOAD_N_IN,
   input wire logic HP_DATA_IN,
   input wire logic [1:0] HP_LATCH_CLK_IN,
   // Bridge core values, index 0 bridge A, index 1 bridge B
   input wire logic [1:0] PARK_EN,
   input wire logic [pin_state_pkg::AD_W-1:0] A_FUNC_AD,
   input wire logic [pin_state_pkg::AD_W-1:0] B_FUNC_AD,
   input wire logic [1:0] FUNC_AD_OE,
   input wire logic [pin_state_pkg::CBE_W-1:0] A_FUNC_CBE,
   input wire logic [pin_state_pkg::CBE_W-1:0] B_FUNC_CBE,
   input wire logic [1:0] FUNC_CBE_OE,
   input wire logic [pin_state_pkg::CTL_W-1:0] A_FUNC_CTL_N,
   input wire logic [pin_state_pkg::CTL_W-1:0] B_FUNC_CTL_N,
   input wire logic [pin_state_pkg::CTL_W-1:0] A_FUNC_CTL_OE,
   input wire logic [pin_state_pkg::CTL_W-1:0] B_FUNC_CTL_OE,
   input wire logic [1:0] INIT_SEL_DRIVE,
   input wire logic [1:0] INIT_SEL_N,
   input wire logic [pin_state_pkg::GNT_W-1:0] A_FUNC_GNT_N,
   input wire logic [pin_state_pkg::GNT_W-1:0] B_FUNC_GNT_N,
   // Bridge A bus pins
   output logic [pin_state_pkg::AD_W-1:0] A_AD_O,
   output logic A_AD_OE,
   output logic [pin_state_pkg::CBE_W-1:0] A_CMD_BYTE_ENABLE_BUS_O,
   output logic A_CMD_BYTE_ENABLE_BUS_OE,
   output logic [pin_state_pkg::CTL_W-1:0] A_CTL_N_O,
   output logic [pin_state_pkg::CTL_W-1:0] A_CTL_OE,
   input wire logic [pin_state_pkg::GNT_W-1:0] A_GNT_N_I,
   output logic [pin_state_pkg::GNT_W-1:0] A_GNT_N_O,
   output logic [pin_state_pkg::GNT_W-1:0] A_GNT_N_OE,
   // Bridge B bus pins
   output logic [pin_state_pkg::AD_W-1:0] B_AD_O,
   output logic B_AD_OE,
   output logic [pin_state_pkg::CBE_W-1:0] B_CMD_BYTE_ENABLE_BUS_O,
   output logic B_CMD_BYTE_ENABLE_BUS_OE,
   output logic [pin_state_pkg::CTL_W-1:0] B_CTL_N_O,
   output logic [pin_state_pkg::CTL_W-1:0] B_CTL_OE,
   input wire logic [pin_state_pkg::GNT_W-1:0] B_GNT_N_I,
   output logic [pin_state_pkg::GNT_W-1:0] B_GNT_N_O,
   output logic [pin_state_pkg::GNT_W-1:0] B_GNT_N_OE,
   // Secondary bus resets, index 0 bridge A
   output logic [1:0] SEC_BUS_RESET_N
);
   import pin_state_pkg::*;

   logic rst_q;
   logic [1:0] pg_meta_q;
   logic pg_q;
   logic pg_prev_q;
   logic [7:0] strap_meta_q;
   logic [7:0] strap_q;
   logic bridge_a_hotplug_enable_q;
   logic bridge_b_hotplug_enable_q;
   logic default_bus_flag_q;
   logic [1:0] freq_a_q;
   logic [1:0] freq_b_q;
   logic [1:0] single_slot_select_n_q;
   logic [1:0] sec_bus_reset_ctrl_q;
   logic [1:0] hp_en;
   logic [1:0] single_slot;
   logic [1:0] sec_rst;
   logic [DATA_W-1:0] rdata_d;

   // Internal reset flag: high until the first edge after release
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         rst_q <= 1'b1;
      end else begin
         rst_q <= 1'b0;
      end
   end

   // Power good comes from a board supervisor, so it is synchronised
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pg_meta_q <= 2'h0;
         pg_q <= 1'b0;
         pg_prev_q <= 1'b0;
      end else begin
         pg_meta_q <= {pg_meta_q[0], POWER_GOOD};
         pg_q <= pg_meta_q[1];
         pg_prev_q <= pg_q;
      end
   end

   // Strap pins take a two-stage path, one stage shorter than the three of power good
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         strap_meta_q <= '0;
         strap_q <= '0;
      end else begin
         strap_meta_q <= {DEFAULT_BUS_STRAP, HP_SERIAL_IN_LOAD_N_I,
            HP_SERIAL_OUT_DATA_I, B_GNT_N_I[4:2], A_GNT_N_I[4:3]};
         strap_q <= strap_meta_q;
      end
   end

   // Straps follow the pins while power is not good and freeze at its rise.
   // The extra stage of pg_q lines up with the strap synchroniser, so the
   // value taken is the one present when power good rose.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         freq_a_q <= 2'h0;
         freq_b_q <= 2'h0;
         bridge_a_hotplug_enable_q <= 1'b0;
         bridge_b_hotplug_enable_q <= 1'b0;
         default_bus_flag_q <= 1'b0;
      end else if (!pg_q) begin
         freq_a_q <= strap_q[1:0]; // RL9 RL17
         freq_b_q <= strap_q[4:3];
         bridge_a_hotplug_enable_q <= strap_q[5]; // RL16
         bridge_b_hotplug_enable_q <= strap_q[6]; // RL16
         default_bus_flag_q <= strap_q[7]; // RL14
      end
   end

   // Single-slot select: B from its strap, A from SSS_N_A_DFLT; software may change both later
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         single_slot_select_n_q <= SSS_N_RST;
      end else if (!pg_q) begin
         single_slot_select_n_q[0] <= SSS_N_A_DFLT;
         single_slot_select_n_q[1] <= strap_q[2]; // RL10 RL17
      end else if (WR && ADDR == CTRL_OFS) begin
         single_slot_select_n_q[0] <= WDATA[CTRL_SSS_A];
         single_slot_select_n_q[1] <= WDATA[CTRL_SSS_B];
      end
   end

   // Software secondary reset bits
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         sec_bus_reset_ctrl_q <= SBR_RST;
      end else if (WR && ADDR == CTRL_OFS) begin
         sec_bus_reset_ctrl_q[0] <= WDATA[CTRL_SBR_A];
         sec_bus_reset_ctrl_q[1] <= WDATA[CTRL_SBR_B];
      end
   end

   // Mode decode per bridge
   assign hp_en = {bridge_b_hotplug_enable_q, bridge_a_hotplug_enable_q};
   assign single_slot = hp_en & ~single_slot_select_n_q; // RL11
   // Only pins see this reset; no internal state is cleared by it
   assign sec_rst = {2{rst_q}} | sec_bus_reset_ctrl_q; // RL15

   // Secondary reset pins, low from the moment reset is applied
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         SEC_BUS_RESET_N <= 2'h0;
      end else begin
         SEC_BUS_RESET_N <= ~sec_rst; // RL15
      end
   end

   // Link data pairs: forced high straight from the asynchronous reset
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         SIDE_A_TX_CAD_PAIR_P <= '1; // RL1 RL3
         SIDE_A_TX_CAD_PAIR_N <= '0;
         SIDE_B_TX_CAD_PAIR_P <= '1; // RL1 RL3
         SIDE_B_TX_CAD_PAIR_N <= '0;
      end else begin
         SIDE_A_TX_CAD_PAIR_P <= TX_CAD_A_IN;
         SIDE_A_TX_CAD_PAIR_N <= ~TX_CAD_A_IN; // RL3
         SIDE_B_TX_CAD_PAIR_P <= TX_CAD_B_IN;
         SIDE_B_TX_CAD_PAIR_N <= ~TX_CAD_B_IN;
      end
   end

   // Link control pairs: forced low during reset
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         TX_CONTROL_PAIR_P <= 2'h0; // RL2 RL3
         TX_CONTROL_PAIR_N <= 2'h3;
      end else begin
         TX_CONTROL_PAIR_P <= TX_CTL_IN;
         TX_CONTROL_PAIR_N <= ~TX_CTL_IN; // RL3
      end
   end

   // Hot plug strap pins turn into outputs once power is good.
   // Without hot plug the load line idles high and the data line low.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         HP_SERIAL_IN_LOAD_N_O <= 1'b1;
         HP_SERIAL_IN_LOAD_N_OE <= 1'b0;
         HP_SERIAL_OUT_DATA_O <= 1'b0;
         HP_SERIAL_OUT_DATA_OE <= 1'b0;
      end else begin
         HP_SERIAL_IN_LOAD_N_OE <= pg_q; // RL16
         HP_SERIAL_OUT_DATA_OE <= pg_q; // RL16
         HP_SERIAL_IN_LOAD_N_O <= (|hp_en) ? HP_LOAD_N_IN : 1'b1;
         HP_SERIAL_OUT_DATA_O <= (|hp_en) && !rst_q && HP_DATA_IN;
      end
   end

   // Bridge A pin states
   bridge_pins #(
      .STRAP_MASK(STRAP_MASK_A)
   ) u_bridge_a (
      .clk(CLOCK),
      .rst_b(RST_B),
      .main_rst(rst_q),
      .sec_rst(sec_rst[0]),
      .single_slot(single_slot[0]),
      .hp_en(hp_en[0]),
      .pg_ok(pg_q),
      .park_en(PARK_EN[0]),
      .func_ad(A_FUNC_AD),
      .func_ad_oe(FUNC_AD_OE[0]),
      .func_cbe(A_FUNC_CBE),
      .func_cbe_oe(FUNC_CBE_OE[0]),
      .func_ctl_n(A_FUNC_CTL_N),
      .func_ctl_oe(A_FUNC_CTL_OE),
      .init_sel_drive(INIT_SEL_DRIVE[0]),
      .init_sel_n(INIT_SEL_N[0]),
      .func_gnt_n(A_FUNC_GNT_N),
      .hp_latch_clk(HP_LATCH_CLK_IN[0]),
      .ad_o(A_AD_O),
      .ad_oe(A_AD_OE),
      .cbe_o(A_CMD_BYTE_ENABLE_BUS_O),
      .cbe_oe(A_CMD_BYTE_ENABLE_BUS_OE),
      .ctl_n_o(A_CTL_N_O),
      .ctl_oe(A_CTL_OE),
      .gnt_n_o(A_GNT_N_O),
      .gnt_oe(A_GNT_N_OE)
   );

   // Bridge B pin states
   bridge_pins #(
      .STRAP_MASK(STRAP_MASK_B)
   ) u_bridge_b (
      .clk(CLOCK),
      .rst_b(RST_B),
      .main_rst(rst_q),
      .sec_rst(sec_rst[1]),
      .single_slot(single_slot[1]),
      .hp_en(hp_en[1]),
      .pg_ok(pg_q),
      .park_en(PARK_EN[1]),
      .func_ad(B_FUNC_AD),
      .func_ad_oe(FUNC_AD_OE[1]),
      .func_cbe(B_FUNC_CBE),
      .func_cbe_oe(FUNC_CBE_OE[1]),
      .func_ctl_n(B_FUNC_CTL_N),
      .func_ctl_oe(B_FUNC_CTL_OE),
      .init_sel_drive(INIT_SEL_DRIVE[1]),
      .init_sel_n(INIT_SEL_N[1]),
      .func_gnt_n(B_FUNC_GNT_N),
      .hp_latch_clk(HP_LATCH_CLK_IN[1]),
      .ad_o(B_AD_O),
      .ad_oe(B_AD_OE),
      .cbe_o(B_CMD_BYTE_ENABLE_BUS_O),
      .cbe_oe(B_CMD_BYTE_ENABLE_BUS_OE),
      .ctl_n_o(B_CTL_N_O),
      .ctl_oe(B_CTL_OE),
      .gnt_n_o(B_GNT_N_O),
      .gnt_oe(B_GNT_N_OE)
   );

   // Read decode; unmapped offsets read as zero
   always_comb begin
      rdata_d = '0;
      case (ADDR)
         CTRL_OFS: begin
            rdata_d[CTRL_SBR_A] = sec_bus_reset_ctrl_q[0];
            rdata_d[CTRL_SBR_B] = sec_bus_reset_ctrl_q[1];
            rdata_d[CTRL_SSS_A] = single_slot_select_n_q[0];
            rdata_d[CTRL_SSS_B] = single_slot_select_n_q[1];
         end
         STAT_OFS: begin
            rdata_d[STAT_HPEN_A] = bridge_a_hotplug_enable_q;
            rdata_d[STAT_HPEN_B] = bridge_b_hotplug_enable_q;
            rdata_d[STAT_DEFBUS] = default_bus_flag_q; // RL14
            rdata_d[STAT_FREQ_A+:2] = freq_a_q; // RL9
            rdata_d[STAT_FREQ_B+:2] = freq_b_q;
            rdata_d[STAT_PGOOD] = pg_q;
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         RDATA <= '0;
      end else begin
         RDATA <= RD ? rdata_d : '0;
      end
   end
endmodule : pin_reset_state_and_straps

// [design/pin_state_pkg.sv]
package pin_state_pkg;
   // Widths of the pin groups
   localparam int AD_W = 64;
   localparam int CBE_W = 8;
   localparam int GNT_W = 5;
   localparam int CTL_W = 4;
   localparam int CAD_A_W = 16;
   localparam int CAD_B_W = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   // Control register fields
   localparam int CTRL_SBR_A = 0;
   localparam int CTRL_SBR_B = 1;
   localparam int CTRL_SSS_A = 2;
   localparam int CTRL_SSS_B = 3;
   // Status register fields
   localparam int STAT_HPEN_A = 0;
   localparam int STAT_HPEN_B = 1;
   localparam int STAT_DEFBUS = 2;
   localparam int STAT_FREQ_A = 3;
   localparam int STAT_FREQ_B = 5;
   localparam int STAT_PGOOD = 7;
   // Control line order inside a bridge
   localparam int CTL_ACK64 = 0;
   localparam int CTL_FRAME = 1;
   localparam int CTL_IRDY = 2;
   localparam int CTL_DEVSEL = 3;
   // Grant lines that carry straps while power is not good
   localparam logic [4:0] STRAP_MASK_A = 5'h18;
   localparam logic [4:0] STRAP_MASK_B = 5'h1C;
   // Values after reset, and the grant pattern of single-slot mode
   localparam logic [1:0] SBR_RST = 2'h0;
   localparam logic [1:0] SSS_N_RST = 2'h3;
   localparam logic [4:0] GNT_IDLE = 5'h1F;
   localparam logic [4:0] GNT_SINGLE = 5'h1E;
   localparam logic [3:0] CTL_IDLE = 4'hF;
endpackage : pin_state_pkg

// [design/bridge_pins.sv]
`timescale 1ns/10ps
module bridge_pins #(
   parameter logic [4:0] STRAP_MASK = 5'h18
) (
   // Clock and reset state
   input wire logic clk,
   input wire logic rst_b,
   input wire logic main_rst,
   input wire logic sec_rst,
   input wire logic single_slot,
   input wire logic hp_en,
   input wire logic pg_ok,
   // Functional values from the bridge core
   input wire logic park_en,
   input wire logic [pin_state_pkg::AD_W-1:0] func_ad,
   input wire logic func_ad_oe,
   input wire logic [pin_state_pkg::CBE_W-1:0] func_cbe,
   input wire logic func_cbe_oe,
   input wire logic [pin_state_pkg::CTL_W-1:0] func_ctl_n,
   input wire logic [pin_state_pkg::CTL_W-1:0] func_ctl_oe,
   input wire logic init_sel_drive,
   input wire logic init_sel_n,
   input wire logic [pin_state_pkg::GNT_W-1:0] func_gnt_n,
   input wire logic hp_latch_clk,
   // Pin drivers
   output logic [pin_state_pkg::AD_W-1:0] ad_o,
   output logic ad_oe,
   output logic [pin_state_pkg::CBE_W-1:0] cbe_o,
   output logic cbe_oe,
   output logic [pin_state_pkg::CTL_W-1:0] ctl_n_o,
   output logic [pin_state_pkg::CTL_W-1:0] ctl_oe,
   output logic [pin_state_pkg::GNT_W-1:0] gnt_n_o,
   output logic [pin_state_pkg::GNT_W-1:0] gnt_oe
);
   import pin_state_pkg::*;

   logic slot_rst;
   logic [GNT_W-1:0] gnt_d;

   // Slot side follows the secondary reset only outside single-slot mode
   assign slot_rst = main_rst | (sec_rst & ~single_slot); // RL4 RL5

   // Address-data and byte enables
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ad_o <= '0;
         ad_oe <= 1'b1;
         cbe_o <= '0;
         cbe_oe <= 1'b1;
      end else if (single_slot || slot_rst) begin
         ad_o <= '0; // RL6
         ad_oe <= 1'b1;
         cbe_o <= '0;
         cbe_oe <= 1'b1;
      end else begin
         // Parking keeps the bus driven when no master owns it
         ad_o <= func_ad;
         ad_oe <= func_ad_oe | park_en; // RL6
         cbe_o <= func_cbe;
         cbe_oe <= func_cbe_oe | park_en;
      end
   end

   // Handshake lines
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_n_o <= CTL_IDLE;
         ctl_oe <= '0;
      end else if (single_slot) begin
         ctl_n_o <= '0; // RL7 RL8 RL11
         ctl_oe <= '1;
      end else if (slot_rst) begin
         ctl_n_o <= CTL_IDLE;
         ctl_oe <= '0; // RL7
         ctl_n_o[CTL_DEVSEL] <= init_sel_n; // RL8
         ctl_oe[CTL_DEVSEL] <= init_sel_drive;
      end else begin
         ctl_n_o <= func_ctl_n;
         ctl_oe <= func_ctl_oe;
      end
   end

   // Grant values by mode; hot plug borrows grant 4 as a latch clock
   always_comb begin
      if (single_slot) begin
         gnt_d = GNT_SINGLE; // RL13 RL11
      end else if (slot_rst) begin
         gnt_d = GNT_IDLE; // RL13
      end else begin
         gnt_d = func_gnt_n;
      end
      if (hp_en && !main_rst) begin
         gnt_d[4] = hp_latch_clk; // RL12
      end
   end

   // Strap grants stay undriven while power is not good
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gnt_n_o <= GNT_IDLE;
         gnt_oe <= ~STRAP_MASK;
      end else begin
         gnt_n_o <= gnt_d;
         gnt_oe <= pg_ok ? GNT_IDLE : ~STRAP_MASK; // RL9 RL10
      end
   end
endmodule : bridge_pins

// [tb/pin_state_sva.sv]
`timescale 1ns/10ps
module pin_state_sva (
   // Clock, reset and power
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic POWER_GOOD,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   // Link transmit
   input wire logic [15:0] TX_CAD_A_IN,
   input wire logic [15:0] SIDE_A_TX_CAD_PAIR_P,
   input wire logic [15:0] SIDE_A_TX_CAD_PAIR_N,
   input wire logic [7:0] SIDE_B_TX_CAD_PAIR_P,
   input wire logic [7:0] SIDE_B_TX_CAD_PAIR_N,
   input wire logic [1:0] TX_CONTROL_PAIR_P,
   input wire logic [1:0] TX_CONTROL_PAIR_N,
   // Bridge pins
   input wire logic [63:0] A_AD_O,
   input wire logic [7:0] A_CMD_BYTE_ENABLE_BUS_O,
   input wire logic [3:0] A_CTL_OE,
   input wire logic [4:0] A_GNT_N_OE,
   input wire logic [4:0] B_GNT_N_OE,
   input wire logic HP_SERIAL_IN_LOAD_N_OE,
   input wire logic HP_SERIAL_OUT_DATA_OE,
   input wire logic [1:0] SEC_BUS_RESET_N
);
   import pin_state_pkg::*;
   default clocking cb @(posedge CLOCK);
   endclocking

   // Checked only while reset is held, so no disable
   a_cad_rst_high: assert property (
      !RST_B |-> SIDE_A_TX_CAD_PAIR_P == 16'hFFFF && SIDE_A_TX_CAD_PAIR_N == 16'h0000
         && SIDE_B_TX_CAD_PAIR_P == 8'hFF && SIDE_B_TX_CAD_PAIR_N == 8'h00)
      else $error("data pair not high in reset");
   a_ctl_rst_low: assert property (
      !RST_B |-> TX_CONTROL_PAIR_P == 2'h0 && TX_CONTROL_PAIR_N == 2'h3)
      else $error("control pair not low in reset");
   a_pair_follow: assert property (disable iff (!RST_B)
      $past(RST_B) |-> SIDE_A_TX_CAD_PAIR_P == $past(TX_CAD_A_IN)
         && SIDE_A_TX_CAD_PAIR_N == ~$past(TX_CAD_A_IN)
         && SIDE_B_TX_CAD_PAIR_N == ~SIDE_B_TX_CAD_PAIR_P)
      else $error("pair legs wrong");
   a_sec_rst_main: assert property (
      !RST_B |-> SEC_BUS_RESET_N == 2'h0)
      else $error("secondary reset not low");
   a_sec_rst_sw: assert property (disable iff (!RST_B)
      WR && ADDR == CTRL_OFS |-> ##2
         SEC_BUS_RESET_N == ~{$past(WDATA[CTRL_SBR_B], 2), $past(WDATA[CTRL_SBR_A], 2)})
      else $error("secondary reset wrong");
   a_bus_rst_state: assert property (
      !RST_B |-> A_AD_O == 64'h0 && A_CMD_BYTE_ENABLE_BUS_O == 8'h00 && A_CTL_OE == 4'h0)
      else $error("bridge pins not reset");
   // Three samples let the registered pins catch up
   a_slot_rst_sec: assert property (disable iff (!RST_B)
      (!SEC_BUS_RESET_N[0])[*3] |-> A_AD_O == 64'h0 && A_CMD_BYTE_ENABLE_BUS_O == 8'h00)
      else $error("slot pins active");
   a_strap_oe_low: assert property (disable iff (!RST_B)
      (!POWER_GOOD)[*6] |-> (A_GNT_N_OE & STRAP_MASK_A) == 5'h00
         && (B_GNT_N_OE & STRAP_MASK_B) == 5'h00)
      else $error("strap grant driven early");
   a_strap_oe_high: assert property (disable iff (!RST_B)
      $rose(POWER_GOOD) |-> ##[2:5] (A_GNT_N_OE == 5'h1F && B_GNT_N_OE == 5'h1F))
      else $error("grants not driven");
   a_hp_oe_low: assert property (disable iff (!RST_B)
      (!POWER_GOOD)[*6] |-> !HP_SERIAL_IN_LOAD_N_OE && !HP_SERIAL_OUT_DATA_OE)
      else $error("hot plug pin driven early");

   // Main scenarios
   c_sw_reset: cover property (WR && ADDR == CTRL_OFS && WDATA[CTRL_SBR_A]);
   c_pg_rise: cover property ($rose(POWER_GOOD));
   c_pg_fall: cover property ($fell(POWER_GOOD));
endmodule : pin_state_sva

// [tb/strap_pull_model.sv]
`timescale 1ns/10ps
module strap_pull_model #(
   parameter int W = 5
) (
   // Device side of the lines
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] oe,
   // Board resistor levels
   input wire logic [W-1:0] pull,
   // Levels the device reads
   output logic [W-1:0] pin
);
   // A released line falls to its resistor level
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin[i] = oe[i] ? drv[i] : pull[i];
      end
   end
endmodule : strap_pull_model

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
   import pin_state_pkg::*;
   // Pins, named as the ports
   logic CLOCK = 1'b0, RST_B = 1'b1, POWER_GOOD = 1'b0, WR = 1'b0, RD = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA, rd_val;
   logic [15:0] TX_CAD_A_IN = 16'hA5C3, SIDE_A_TX_CAD_PAIR_P, SIDE_A_TX_CAD_PAIR_N;
   logic [7:0] TX_CAD_B_IN = 8'h3C, SIDE_B_TX_CAD_PAIR_P, SIDE_B_TX_CAD_PAIR_N;
   logic [1:0] TX_CTL_IN = 2'h1, TX_CONTROL_PAIR_P, TX_CONTROL_PAIR_N, SEC_BUS_RESET_N;
   logic DEFAULT_BUS_STRAP = 1'b1, HP_LOAD_N_IN = 1'b1, HP_DATA_IN = 1'b0;
   logic HP_SERIAL_IN_LOAD_N_I, HP_SERIAL_IN_LOAD_N_O, HP_SERIAL_IN_LOAD_N_OE;
   logic HP_SERIAL_OUT_DATA_I, HP_SERIAL_OUT_DATA_O, HP_SERIAL_OUT_DATA_OE;
   logic [1:0] HP_LATCH_CLK_IN = 2'h3, PARK_EN = 2'h0, FUNC_AD_OE = 2'h3, FUNC_CBE_OE = 2'h3;
   logic [1:0] INIT_SEL_DRIVE = 2'h0, INIT_SEL_N = 2'h3;
   logic [63:0] A_FUNC_AD = 64'h0123456789ABCDEF, B_FUNC_AD = 64'hFEDCBA9876543210;
   logic [63:0] A_AD_O, B_AD_O;
   logic [7:0] A_FUNC_CBE = 8'h5A, B_FUNC_CBE = 8'hA5;
   logic [7:0] A_CMD_BYTE_ENABLE_BUS_O, B_CMD_BYTE_ENABLE_BUS_O;
   logic [3:0] A_FUNC_CTL_N = 4'h5, B_FUNC_CTL_N = 4'hA, A_FUNC_CTL_OE = 4'h0;
   logic [3:0] B_FUNC_CTL_OE = 4'h0, A_CTL_N_O, A_CTL_OE, B_CTL_N_O, B_CTL_OE;
   logic [4:0] A_FUNC_GNT_N = 5'h1F, B_FUNC_GNT_N = 5'h00, A_GNT_N_I, A_GNT_N_O, A_GNT_N_OE;
   logic [4:0] B_GNT_N_I, B_GNT_N_O, B_GNT_N_OE;
   logic A_AD_OE, B_AD_OE, A_CMD_BYTE_ENABLE_BUS_OE, B_CMD_BYTE_ENABLE_BUS_OE;
   // Board strap levels: B hot plug on, A off, B select strap low
   logic [4:0] pull_a = 5'h17, pull_b = 5'h0B;
   logic pull_load = 1'b1, pull_data = 1'b0;
   int miscompares = 0, checked = 0;

   pin_reset_state_and_straps u_pin_reset_state_and_straps (.*);
   strap_pull_model u_pull_a (.drv(A_GNT_N_O), .oe(A_GNT_N_OE), .pull(pull_a),
      .pin(A_GNT_N_I));
   strap_pull_model u_pull_b (.drv(B_GNT_N_O), .oe(B_GNT_N_OE), .pull(pull_b),
      .pin(B_GNT_N_I));
   strap_pull_model #(.W(1)) u_pull_load (.drv(HP_SERIAL_IN_LOAD_N_O),
      .oe(HP_SERIAL_IN_LOAD_N_OE), .pull(pull_load), .pin(HP_SERIAL_IN_LOAD_N_I));
   strap_pull_model #(.W(1)) u_pull_data (.drv(HP_SERIAL_OUT_DATA_O),
      .oe(HP_SERIAL_OUT_DATA_OE), .pull(pull_data), .pin(HP_SERIAL_OUT_DATA_I));

   // 25 MHz clock
   always #20 CLOCK = ~CLOCK;

   task automatic check(input string what, input logic [63:0] exp, got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Waits end past the edge, once outputs settle
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : cyc

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask : reg_rd

   // Expected status for given straps
   function automatic logic [31:0] stat_of(input logic pg, input logic [4:0] pa, pb,
      input logic ld, dt);
      return {24'h0, pg, pb[4:3], pa[4:3], DEFAULT_BUS_STRAP, ld, dt};
   endfunction : stat_of

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   initial begin
      RST_B <= 1'b0;
      cyc(3);
      check("cad_a_p_rst", 64'hFFFF, SIDE_A_TX_CAD_PAIR_P);
      check("cad_b_n_rst", 64'h0, SIDE_B_TX_CAD_PAIR_N);
      check("ctl_p_rst", 64'h0, TX_CONTROL_PAIR_P);
      check("ctl_n_rst", 64'h3, TX_CONTROL_PAIR_N);
      check("gnt_oe_rst", {59'h0, ~STRAP_MASK_B}, B_GNT_N_OE);
      cyc(17);
      @(posedge CLOCK);
      RST_B <= 1'b1;
      cyc(3);
      check("cad_a_p", 64'hA5C3, SIDE_A_TX_CAD_PAIR_P);
      check("cad_a_n", 64'h5A3C, SIDE_A_TX_CAD_PAIR_N);
      check("ctl_n", 64'h2, TX_CONTROL_PAIR_N);
      check("hp_oe_low", 64'h0, HP_SERIAL_OUT_DATA_OE);
      $display("test link_pairs done");
      // Power good rises; later strap changes are ignored
      @(posedge CLOCK);
      POWER_GOOD <= 1'b1;
      TX_CAD_A_IN <= 16'h1E78;
      cyc(6);
      check("cad_a_p_new", 64'h1E78, SIDE_A_TX_CAD_PAIR_P);
      check("gnt_oe_a", 64'h1F, A_GNT_N_OE);
      check("hp_oe", 64'h1, HP_SERIAL_IN_LOAD_N_OE);
      pull_a = 5'h0F;
      pull_data = 1'b1;
      reg_rd(STAT_OFS, rd_val);
      check("status", stat_of(1'b1, 5'h17, 5'h0B, 1'b1, 1'b0), rd_val);
      reg_rd(CTRL_OFS, rd_val);
      check("ctrl", {28'h0, pull_b[2], 3'h4}, rd_val);
      $display("test strap_capture done");
      // B single-slot, A normal
      check("b_gnt", 64'h1E, B_GNT_N_O);
      check("b_ctl", 64'h0, B_CTL_N_O);
      check("b_ctl_oe", 64'hF, B_CTL_OE);
      check("b_ad", 64'h0, B_AD_O);
      check("b_cbe", 64'h0, B_CMD_BYTE_ENABLE_BUS_O);
      check("a_ad", A_FUNC_AD, A_AD_O);
      check("a_ctl_oe", 64'h0, A_CTL_OE);
      @(posedge CLOCK);
      HP_LATCH_CLK_IN <= 2'h1;
      cyc(3);
      check("b_gnt4", 64'h0E, B_GNT_N_O);
      $display("test single_slot done");
      // Software secondary reset per bridge
      reg_wr(CTRL_OFS, 32'h5);
      cyc(3);
      check("sec_rst_a", 64'h2, SEC_BUS_RESET_N);
      check("a_ad_sbr", 64'h0, A_AD_O);
      reg_wr(CTRL_OFS, 32'h6);
      cyc(3);
      check("sec_rst_b", 64'h1, SEC_BUS_RESET_N);
      check("a_ad_back", A_FUNC_AD, A_AD_O);
      check("b_ctl_oe_sbr", 64'hF, B_CTL_OE);
      reg_wr(CTRL_OFS, 32'h4);
      $display("test sec_reset done");
      // Power lost: straps retaken, select writes refused
      @(posedge CLOCK);
      POWER_GOOD <= 1'b0;
      cyc(6);
      check("gnt_oe_pg_low", {59'h0, ~STRAP_MASK_A}, A_GNT_N_OE);
      reg_wr(CTRL_OFS, 32'hC);
      reg_rd(STAT_OFS, rd_val);
      check("status_new", stat_of(1'b0, 5'h0F, 5'h0B, 1'b1, 1'b1), rd_val);
      reg_rd(CTRL_OFS, rd_val);
      check("ctrl_refused", {28'h0, pull_b[2], 3'h4}, rd_val);
      // Bridge A now hot plug with switches
      @(posedge CLOCK);
      POWER_GOOD <= 1'b1;
      HP_LATCH_CLK_IN <= 2'h2;
      cyc(6);
      check("a_gnt4", 64'h0, A_GNT_N_O[4]);
      check("a_ctl_oe_hp", 64'h0, A_CTL_OE);
      check("b_gnt_hp", 64'h1E, B_GNT_N_O);
      $display("test power_cycle done");
      // Main reset in mid-run
      @(posedge CLOCK);
      RST_B <= 1'b0;
      cyc(2);
      check("cad_b_p_rst2", 64'hFF, SIDE_B_TX_CAD_PAIR_P);
      check("sec_rst2", 64'h0, SEC_BUS_RESET_N);
      check("a_ad_rst2", 64'h0, A_AD_O);
      @(posedge CLOCK);
      RST_B <= 1'b1;
      cyc(3);
      check("sec_rst_rel", 64'h3, SEC_BUS_RESET_N);
      $display("test second_reset done");
      test_done();
   end
endmodule : testbench

bind pin_reset_state_and_straps pin_state_sva u_pin_state_sva (.*);
